// [bench/epil_cpu_model.sv]
module epil_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_cmd,
    input wire logic auto_en,
    input wire logic slow,
    input wire logic irq_req,
    output logic pin_n,
    output logic fetch
);
    logic req_d = 1'b0;
    initial pin_n = 1'b1;
    initial fetch = 1'b0;
    always @(posedge clk) begin
        pin_n <= pin_cmd;
        req_d <= irq_req && !rst;
        // One-cycle vector fetch, optionally a cycle late
        fetch <= !rst && auto_en && !fetch && (slow ? req_d : irq_req);
    end
endmodule

// [bench/epil_props.sv]
module epil_props (
    input wire ref_clk_in,
    input wire reset_in,
    input wire irq_pin_n_in,
    input wire vector_fetch_in,
    input wire cpu_global_mask_in,
    input wire s_axi_awvalid_in,
    input wire s_axi_awready_out,
    input wire s_axi_wvalid_in,
    input wire s_axi_wready_out,
    input wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire s_axi_arvalid_in,
    input wire s_axi_arready_out,
    input wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire [31:0] s_axi_rdata_out,
    input wire cpu_irq_req_out,
    input wire [15:0] cpu_vector_addr_out,
    input wire pin_level_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence pin_hi; irq_pin_n_in [*6]; endsequence
    sequence pin_lo; !irq_pin_n_in [*6]; endsequence
    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out &&
        s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    a_global_mask: assert property (
        cpu_global_mask_in |-> !cpu_irq_req_out) else $error("gmask");
    a_vector_addr: assert property (
        cpu_vector_addr_out == 16'hFFFA) else $error("vector");
    a_fetch_clear: assert property (
        pin_hi ##0 vector_fetch_in |=> !cpu_irq_req_out) else $error("fetch");
    a_pin_high: assert property (
        pin_hi |-> pin_level_out) else $error("pin high");
    a_pin_low: assert property (
        pin_lo |-> !pin_level_out) else $error("pin low");
    a_write_resp: assert property (
        wr_taken |=> ##1 s_axi_bvalid_out) else $error("bvalid late");
    a_bvalid_hold: assert property (
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("bvalid dropped");
    a_read_resp: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("rvalid late");
    a_rdata_hold: assert property (
        s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("rdata");
endmodule

bind epil_top epil_props i_props (.*);

// [bench/external_pin_interrupt_latch_tb.sv]
`define EDGE @(posedge ref_clk_in)
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module external_pin_interrupt_latch_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 0, reset_in = 1, break_state_in = 0, pin_cmd = 1;
    logic break_clear_enable_in = 0, cpu_global_mask_in = 0;
    logic auto_en = 0, slow = 0;
    logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
    logic [31:0] s_axi_wdata_in = 0;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, irq_out;
    wire s_axi_arready_out, s_axi_rvalid_out, cpu_irq_req_out, pin_level_out;
    wire irq_pin_n_in, vector_fetch_in;
    wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire [15:0] cpu_vector_addr_out;
    integer errors = 0, num_checks = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    epil_top i_dut (.*);
    epil_cpu_model i_cpu (.clk(ref_clk_in), .rst(reset_in), .pin_cmd(pin_cmd),
        .auto_en(auto_en), .slow(slow), .irq_req(cpu_irq_req_out),
        .pin_n(irq_pin_n_in), .fetch(vector_fetch_in));
    task automatic wr(input [7:0] a, input [7:0] d);
        `EDGE s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h000000, d};
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        fork
            begin do `EDGE; while (!s_axi_awready_out); s_axi_awvalid_in <= 0; end
            begin do `EDGE; while (!s_axi_wready_out); s_axi_wvalid_in <= 0; end
        join
        `EDGE s_axi_bready_in <= 1;
        do `EDGE; while (!s_axi_bvalid_out);
        s_axi_bready_in <= 0;
        `CHK("bresp", 2'h0, s_axi_bresp_out)
    endtask
    task automatic rd(input [7:0] a, input [31:0] e, input [1:0] r);
        `EDGE s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        do `EDGE; while (!s_axi_arready_out);
        s_axi_arvalid_in <= 0;
        `EDGE s_axi_rready_in <= 1;
        do `EDGE; while (!s_axi_rvalid_out);
        s_axi_rready_in <= 0;
        `CHK("rdata", e, s_axi_rdata_out)
        `CHK("rresp", r, s_axi_rresp_out)
    endtask
    task automatic set_pin(input v);
        `EDGE pin_cmd <= v;
        repeat (8) `EDGE;
    endtask
    task report_and_stop;
        if (errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
    initial begin
        repeat (12) `EDGE;
        reset_in <= 0;
        rd(8'h00, 32'h00000000, 2'h0);
        rd(8'h0C, 32'hFFFBFFFA, 2'h0);
        rd(8'h10, 32'h00000000, 2'h2);
        set_pin(0);
        `CHK("req", 1'b1, cpu_irq_req_out)
        cpu_global_mask_in <= 1;
        `EDGE `CHK("req", 1'b0, cpu_irq_req_out)
        cpu_global_mask_in <= 0;
        wr(8'h00, 8'h02);
        `CHK("req", 1'b0, cpu_irq_req_out)
        rd(8'h00, 32'h0000000A, 2'h0);
        wr(8'h08, 8'h03);
        `CHK("irq", 1'b1, irq_out)
        wr(8'h00, 8'h06);
        rd(8'h00, 32'h00000002, 2'h0);
        rd(8'h04, 32'h00000003, 2'h0);
        wr(8'h04, 8'h03);
        `CHK("irq", 1'b0, irq_out)
        set_pin(1);
        set_pin(0);
        rd(8'h00, 32'h0000000A, 2'h0);
        break_state_in <= 1;
        wr(8'h00, 8'h06);
        rd(8'h00, 32'h0000000A, 2'h0);
        break_clear_enable_in <= 1;
        wr(8'h00, 8'h06);
        break_state_in <= 0;
        rd(8'h00, 32'h00000002, 2'h0);
        wr(8'h00, 8'h03);
        rd(8'h00, 32'h0000000B, 2'h0);
        wr(8'h00, 8'h07);
        rd(8'h00, 32'h0000000B, 2'h0);
        set_pin(1);
        rd(8'h00, 32'h00000003, 2'h0);
        set_pin(0);
        set_pin(1);
        slow <= 1;
        auto_en <= 1;
        wr(8'h00, 8'h01);
        repeat (6) `EDGE;
        rd(8'h00, 32'h00000001, 2'h0);
        slow <= 0;
        wr(8'h00, 8'h00);
        set_pin(0);
        rd(8'h00, 32'h00000000, 2'h0);
        auto_en <= 0;
        wr(8'h00, 8'h01);
        reset_in <= 1;
        `EDGE `EDGE `CHK("req", 1'b0, cpu_irq_req_out)
        set_pin(1);
        reset_in <= 0;
        rd(8'h00, 32'h00000000, 2'h0);
        report_and_stop;
    end
endmodule

// [logic/epil_defines.vh]
`ifndef EPIL_DEFINES_VH
`define EPIL_DEFINES_VH

// Register byte offsets
`define EPIL_OFS_ISC 8'h00
`define EPIL_OFS_IRQ_STAT 8'h04
`define EPIL_OFS_IRQ_MASK 8'h08
`define EPIL_OFS_VECTOR 8'h0C

// Status and control register field positions
`define EPIL_BIT_MODE 0
`define EPIL_BIT_MASK 1
`define EPIL_BIT_ACK 2
`define EPIL_BIT_PEND 3

// Event status bit positions
`define EPIL_EV_LATCH 0
`define EPIL_EV_ACK 1

// Reset values
`define EPIL_RST_MODE 1'b0
`define EPIL_RST_MASK 1'b0
`define EPIL_RST_EV 2'h0
`define EPIL_RST_EVMASK 2'h0

// Vector locations the CPU is directed to
`define EPIL_VEC_HI_ADDR 16'hFFFA
`define EPIL_VEC_LO_ADDR 16'hFFFB

// AXI responses
`define EPIL_RESP_OKAY 2'h0
`define EPIL_RESP_SLVERR 2'h2

`endif

// [logic/epil_top.v]
`include "epil_defines.vh"

module epil_top (
    input wire ref_clk_in,
    input wire reset_in,
    input wire irq_pin_n_in,
    input wire vector_fetch_in,
    input wire break_state_in,
    input wire break_clear_enable_in,
    input wire cpu_global_mask_in,
    input wire [7:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [7:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    output wire cpu_irq_req_out,
    output wire [15:0] cpu_vector_addr_out,
    output reg pin_level_out,
    output wire irq_out
);
    reg pin_meta_r;
    reg pin_sync_r;
    reg latch_r;
    reg mode_r;
    reg mask_r;
    reg [1:0] ev_stat_r;
    reg [1:0] ev_mask_r;
    reg aw_held_r;
    reg [7:0] aw_addr_r;
    reg w_held_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg latch_nxt;
    reg ack_pend_r;
    reg ack_pend_nxt;
    reg [1:0] ev_stat_nxt;
    reg [31:0] rd_word;
    reg rd_ok;
    wire wr_fire;
    wire wr_isc;
    wire sw_ack;
    wire ack;
    wire fall_edge;

    // Two-stage synchroniser; third stage pin_level_out holds the previous sample
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            pin_level_out <= 1'b1;
        end else begin
            pin_meta_r <= irq_pin_n_in;
            pin_sync_r <= pin_meta_r;
            pin_level_out <= pin_sync_r;
        end
    end

    assign fall_edge = pin_level_out & ~pin_sync_r;

    // Write side: address and data accepted in either order
    assign s_axi_awready_out = ~aw_held_r & ~s_axi_bvalid_out;
    assign s_axi_wready_out = ~w_held_r & ~s_axi_bvalid_out;
    assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid_out;
    assign wr_isc = wr_fire & (aw_addr_r == `EPIL_OFS_ISC) & w_strb_r[0];
    assign sw_ack = wr_isc & w_data_r[`EPIL_BIT_ACK];
    // Break state gates software acknowledges only
    assign ack = vector_fetch_in |
        (sw_ack & (~break_state_in | break_clear_enable_in));

    always @* begin
        latch_nxt = latch_r;
        if ((ack || ack_pend_r) && (!mode_r || pin_sync_r))
            latch_nxt = 1'b0;
        // Set wins over acknowledge so a new edge is never lost
        if (fall_edge || (mode_r && !pin_sync_r))
            latch_nxt = 1'b1;
        // Level mode: acknowledge seen while pin low waits for release
        ack_pend_nxt = latch_nxt && mode_r && !fall_edge &&
            (ack_pend_r || ack);
    end

    always @* begin
        ev_stat_nxt = ev_stat_r;
        if (wr_fire && aw_addr_r == `EPIL_OFS_IRQ_STAT && w_strb_r[0])
            ev_stat_nxt = ev_stat_r & ~w_data_r[1:0];
        if (!latch_r && latch_nxt)
            ev_stat_nxt[`EPIL_EV_LATCH] = 1'b1;
        if (ack)
            ev_stat_nxt[`EPIL_EV_ACK] = 1'b1;
    end

    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            latch_r <= 1'b0;
            ack_pend_r <= 1'b0;
            mode_r <= `EPIL_RST_MODE;
            mask_r <= `EPIL_RST_MASK;
            ev_stat_r <= `EPIL_RST_EV;
            ev_mask_r <= `EPIL_RST_EVMASK;
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `EPIL_RESP_OKAY;
        end else begin
            latch_r <= latch_nxt;
            ack_pend_r <= ack_pend_nxt;
            ev_stat_r <= ev_stat_nxt;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr_in[7:2], 2'b00};
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_in;
                w_strb_r <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= `EPIL_RESP_OKAY;
                case (aw_addr_r)
                    `EPIL_OFS_ISC: begin
                        if (w_strb_r[0]) begin
                            mode_r <= w_data_r[`EPIL_BIT_MODE];
                            mask_r <= w_data_r[`EPIL_BIT_MASK];
                        end
                    end
                    `EPIL_OFS_IRQ_MASK: begin
                        if (w_strb_r[0])
                            ev_mask_r <= w_data_r[1:0];
                    end
                    `EPIL_OFS_IRQ_STAT: begin
                    end
                    `EPIL_OFS_VECTOR: begin
                    end
                    default: s_axi_bresp_out <= `EPIL_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Read side
    assign s_axi_arready_out = ~s_axi_rvalid_out;

    always @* begin
        rd_word = 32'h00000000;
        rd_ok = 1'b1;
        case ({s_axi_araddr_in[7:2], 2'b00})
            `EPIL_OFS_ISC: begin
                // Acknowledge bit left at zero
                rd_word[`EPIL_BIT_MODE] = mode_r;
                rd_word[`EPIL_BIT_MASK] = mask_r;
                rd_word[`EPIL_BIT_PEND] = latch_r;
            end
            `EPIL_OFS_IRQ_STAT: rd_word[1:0] = ev_stat_r;
            `EPIL_OFS_IRQ_MASK: rd_word[1:0] = ev_mask_r;
            `EPIL_OFS_VECTOR: rd_word = {`EPIL_VEC_LO_ADDR,
                `EPIL_VEC_HI_ADDR};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `EPIL_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= rd_ok ? `EPIL_RESP_OKAY : `EPIL_RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // CPU request: local mask and global mask both block it
    assign cpu_irq_req_out = latch_r & ~mask_r & ~cpu_global_mask_in;
    assign cpu_vector_addr_out = `EPIL_VEC_HI_ADDR;
    assign irq_out = |(ev_stat_r & ev_mask_r);

endmodule
